// ==== inc/ocsr_defines.svh ====
`ifndef OCSR_DEFINES_SVH
`define OCSR_DEFINES_SVH

`define OCSR_ADDR_MODE_CONFIG 8'h13
`define OCSR_ADDR_BIAS_DAC 8'h14
`define OCSR_ADDR_MOD_DAC 8'h15
`define OCSR_ADDR_STATUS 8'h16
`define OCSR_ADDR_LOSS_DEASSERT 8'h17
`define OCSR_ADDR_RX_POT 8'h18

`define OCSR_RST_MODE_CONFIG 8'h08
`define OCSR_RST_LOSS_DEASSERT 8'h00
`define OCSR_RST_RX_POT 5'h00
`define OCSR_RST_BYTE 8'h00

`define OCSR_CFG_TABLE_INPUT 7
`define OCSR_CFG_FAULT_POL 6
`define OCSR_CFG_GP_DRIVE 5
`define OCSR_CFG_GP_MODE 4
`define OCSR_CFG_GP_LEVEL 3
`define OCSR_CFG_FAULT_MODE 2
`define OCSR_CFG_LOSS_DIS 1
`define OCSR_CFG_INT_CAL 0

`define OCSR_ST_INT 4
`define OCSR_ST_SAT 3
`define OCSR_ST_OVERCUR 2
`define OCSR_ST_TXPWR 1
`define OCSR_ST_RATE 0

`define OCSR_POT_FULL 6'h20

`endif

// ==== inc/ocsr_pkg.sv ====
package ocsr_pkg;
  typedef logic [7:0] ocsr_byte_t;
  typedef enum logic {OCSR_LOS_CLEAR, OCSR_LOS_ASSERTED} ocsr_los_t;
endpackage : ocsr_pkg

// ==== rtl/ocsr_regs.sv ====
`timescale 1ns/1ps
`include "ocsr_defines.svh"
// Contract
// - Table input: rx power or temperature, internal-cal only
// - Fault flagged when pin equals polarity bit
// - General output open-drain or push-pull per drive bit
// - Shared pin: rate select or general output
// - General output level follows level bit
// - Shared input: shutdown or fault input
// - Disable bit turns loss comparator off
// - Calibration bit selects internal or external
// - Bias readback shows selected setpoint, resets zero
// - Modulation readback shows setpoint, resets zero
// - Access only while OEM password valid
// - Status without password: undefined read, write ignored
// - Status shows interrupt active-high logical state
// - Status shows bias-loop saturation flag
// - Status shows overcurrent and tx power flags
// - Status shows rate-select pin level
// - Upper status bits reserved, host writes zero
// - Loss asserts below assert threshold
// - Loss deasserts only above deassert threshold
// - Received power scaled by pot tap first
// - Disabled comparator ignores deassert threshold
// - Deassert threshold survives resets
// - Tap zero bypasses, else ratio (32-n)/32
// - Mode config survives resets, default 08h
module ocsr_regs
  import ocsr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic oem_unlocked_i,
  input wire logic [1:0] bias_setpoint_sel_i,
  input wire logic [7:0] bias_setpoint_a_i,
  input wire logic [7:0] bias_setpoint_b_i,
  input wire logic [7:0] bias_setpoint_c_i,
  input wire logic [7:0] modulation_setpoint_i,
  input wire logic interrupt_active_i,
  input wire logic bias_loop_saturation_flag_i,
  input wire logic bias_overcurrent_flag_i,
  input wire logic tx_power_fault_flag_i,
  input wire logic fault_pin_i,
  input wire logic rate_select_i,
  input wire logic gp_pin_i,
  output logic gp_pin_o,
  output logic gp_pin_oe_n_o,
  input wire logic [7:0] rx_power_input_i,
  input wire logic [7:0] loss_assert_threshold_i,
  output logic table_input_select_o,
  output logic internal_cal_select_o,
  output logic tx_fault_o,
  output logic shutdown_input_o,
  output logic rx_loss_o
);

  ocsr_byte_t oem_mode_config;
  ocsr_byte_t loss_deassert_threshold;
  logic [4:0] rx_pot_tap_select;
  ocsr_byte_t bias_dac_readback;
  ocsr_byte_t modulation_dac_readback;
  ocsr_byte_t next_rdata;
  ocsr_los_t los_state;
  ocsr_los_t next_los_state;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] pins_raw;

  wire wr_ok = reg_wr_i && oem_unlocked_i;
  wire rd_ok = reg_rd_i && oem_unlocked_i;
  wire wr_cfg = wr_ok && (reg_addr_i == `OCSR_ADDR_MODE_CONFIG);
  wire wr_deassert = wr_ok && (reg_addr_i == `OCSR_ADDR_LOSS_DEASSERT);
  wire wr_pot = wr_ok && (reg_addr_i == `OCSR_ADDR_RX_POT);

  // Two-flop synchronisers for pins and analog comparator outputs
  assign pins_raw = {gp_pin_i, fault_pin_i, bias_overcurrent_flag_i, bias_loop_saturation_flag_i};
  wire sat_s = sync_b[0];
  wire overcur_s = sync_b[1];
  wire fault_pin_s = sync_b[2];
  wire gp_pin_s = sync_b[3];

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= 4'h0;
      sync_b <= 4'h0;
    end
    else
    begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  logic txpwr_a;
  logic txpwr_s;
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      txpwr_a <= 1'b0;
      txpwr_s <= 1'b0;
    end
    else
    begin
      txpwr_a <= tx_power_fault_flag_i;
      txpwr_s <= txpwr_a;
    end
  end

  // Non-volatile bytes: only power-on restores them, functional reset leaves them
  always_ff @(posedge mclk_i or negedge por_n_i)
  begin
    if (!por_n_i)
    begin
      oem_mode_config <= `OCSR_RST_MODE_CONFIG;
      loss_deassert_threshold <= `OCSR_RST_LOSS_DEASSERT;
      rx_pot_tap_select <= `OCSR_RST_RX_POT;
    end
    else
    begin
      if (wr_cfg)
        oem_mode_config <= reg_wdata_i;
      if (wr_deassert)
        loss_deassert_threshold <= reg_wdata_i;
      if (wr_pot)
        rx_pot_tap_select <= reg_wdata_i[4:0];
    end
  end

  // Mode decode
  wire cfg_int_cal = oem_mode_config[`OCSR_CFG_INT_CAL];
  wire cfg_fault_mode = oem_mode_config[`OCSR_CFG_FAULT_MODE];
  wire cfg_gp_mode = oem_mode_config[`OCSR_CFG_GP_MODE];
  wire cfg_gp_drive = oem_mode_config[`OCSR_CFG_GP_DRIVE];
  wire cfg_gp_level = oem_mode_config[`OCSR_CFG_GP_LEVEL];
  wire cfg_loss_dis = oem_mode_config[`OCSR_CFG_LOSS_DIS];
  wire cfg_fault_pol = oem_mode_config[`OCSR_CFG_FAULT_POL];
  wire cfg_table = oem_mode_config[`OCSR_CFG_TABLE_INPUT];

  wire next_table = cfg_int_cal && cfg_table;
  wire next_tx_fault = cfg_fault_mode && (fault_pin_s == cfg_fault_pol);
  wire next_shutdown = !cfg_fault_mode && fault_pin_s;
  wire gp_value = cfg_gp_mode ? cfg_gp_level : rate_select_i;
  wire gp_push = !cfg_gp_mode || cfg_gp_drive;
  wire next_oe_n = !(gp_push || !gp_value);
  wire next_pin_o = gp_push ? gp_value : 1'b0;

  // Pot divider scaling
  wire [5:0] pot_ratio = `OCSR_POT_FULL - {1'b0, rx_pot_tap_select};
  wire [13:0] pot_prod = rx_power_input_i * pot_ratio;
  wire [7:0] rx_scaled = (rx_pot_tap_select == 5'h00) ? rx_power_input_i : pot_prod[12:5];

  // Loss-of-signal hysteresis
  always_comb
  begin
    next_los_state = los_state;
    case (los_state)
      OCSR_LOS_CLEAR:
        if (rx_scaled < loss_assert_threshold_i)
          next_los_state = OCSR_LOS_ASSERTED;
      OCSR_LOS_ASSERTED:
        if (rx_scaled > loss_deassert_threshold)
          next_los_state = OCSR_LOS_CLEAR;
      default:
        next_los_state = OCSR_LOS_CLEAR;
    endcase
    if (cfg_loss_dis)
      next_los_state = OCSR_LOS_CLEAR;
  end

  // Live status, sampled only at read time
  wire [7:0] status_live = {3'b000, interrupt_active_i, sat_s, overcur_s, txpwr_s, gp_pin_s};

  wire [7:0] bias_sel = (bias_setpoint_sel_i == 2'h0) ? bias_setpoint_a_i :
                        (bias_setpoint_sel_i == 2'h1) ? bias_setpoint_b_i : bias_setpoint_c_i;

  always_comb
  begin
    next_rdata = `OCSR_RST_BYTE;
    case (reg_addr_i)
      `OCSR_ADDR_MODE_CONFIG: next_rdata = oem_mode_config;
      `OCSR_ADDR_BIAS_DAC: next_rdata = bias_dac_readback;
      `OCSR_ADDR_MOD_DAC: next_rdata = modulation_dac_readback;
      `OCSR_ADDR_STATUS: next_rdata = status_live;
      `OCSR_ADDR_LOSS_DEASSERT: next_rdata = loss_deassert_threshold;
      `OCSR_ADDR_RX_POT: next_rdata = {3'b000, rx_pot_tap_select};
      default: next_rdata = `OCSR_RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bias_dac_readback <= `OCSR_RST_BYTE;
      modulation_dac_readback <= `OCSR_RST_BYTE;
      reg_rdata_o <= `OCSR_RST_BYTE;
      los_state <= OCSR_LOS_CLEAR;
      table_input_select_o <= 1'b0;
      internal_cal_select_o <= 1'b0;
      tx_fault_o <= 1'b0;
      shutdown_input_o <= 1'b0;
      gp_pin_o <= 1'b0;
      gp_pin_oe_n_o <= 1'b1;
    end
    else
    begin
      bias_dac_readback <= bias_sel;
      modulation_dac_readback <= modulation_setpoint_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_ok ? next_rdata : `OCSR_RST_BYTE;
      los_state <= next_los_state;
      table_input_select_o <= next_table;
      internal_cal_select_o <= cfg_int_cal;
      tx_fault_o <= next_tx_fault;
      shutdown_input_o <= next_shutdown;
      gp_pin_o <= next_pin_o;
      gp_pin_oe_n_o <= next_oe_n;
    end
  end

  assign rx_loss_o = (los_state == OCSR_LOS_ASSERTED);

endmodule : ocsr_regs

// ==== tb/ocsr_pin_env.sv ====
`timescale 1ns/1ps
module ocsr_pin_env (
  input wire logic pin_i,
  input wire logic oe_n_i,
  output logic pin_lvl_o
);
  // Released pin floats to the pull-up level
  assign pin_lvl_o = oe_n_i ? 1'b1 : pin_i;
endmodule : ocsr_pin_env

// ==== tb/ocsr_regs_properties.sv ====
`timescale 1ns/1ps
module ocsr_regs_chk (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic oem_unlocked_i,
  input wire logic [7:0] modulation_setpoint_i,
  input wire logic interrupt_active_i,
  input wire logic gp_pin_i,
  input wire logic internal_cal_select_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic rd_ok = reg_rd_i && oem_unlocked_i;
  wire logic st_rd = rd_ok && reg_addr_i == 8'h16;
  wire logic cfg_ok = reg_wr_i && oem_unlocked_i && reg_addr_i == 8'h13;
  wire logic cfg_lk = reg_wr_i && !oem_unlocked_i && reg_addr_i == 8'h13;
  cfg_apply_a: assert property (cfg_ok |=> ##1 internal_cal_select_o == $past(reg_wdata_i[0], 2))
    else $error("config write not applied");
  cfg_lock_a: assert property (cfg_lk |=> ##1 $stable(internal_cal_select_o))
    else $error("locked config write took effect");
  lock_read_a: assert property (reg_rd_i && !oem_unlocked_i |=> reg_rdata_o == 8'h00)
    else $error("locked read not zero");
  st_resv_a: assert property (st_rd |=> reg_rdata_o[7:5] == 3'h0)
    else $error("status reserved bits set");
  st_int_a: assert property (st_rd |=> reg_rdata_o[4] == $past(interrupt_active_i))
    else $error("status interrupt bit wrong");
  st_rate_a: assert property (st_rd |=> reg_rdata_o[0] == $past(gp_pin_i, 3))
    else $error("status pin bit wrong");
  pot_resv_a: assert property (rd_ok && reg_addr_i == 8'h18 |=> reg_rdata_o[7:5] == 3'h0)
    else $error("tap upper bits set");
  mod_rb_a: assert property (rd_ok && reg_addr_i == 8'h15 |=> reg_rdata_o == $past(modulation_setpoint_i, 2))
    else $error("modulation readback wrong");
endmodule : ocsr_regs_chk
bind ocsr_regs ocsr_regs_chk u_chk (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
  .reg_rdata_o, .oem_unlocked_i, .modulation_setpoint_i, .interrupt_active_i, .gp_pin_i, .internal_cal_select_o);

// ==== tb/ocsr_regs_tb.sv ====
`timescale 1ns/1ps
module ocsr_regs_tb;
  logic mclk_i = 0, rst_n_i = 0, por_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, oem_unlocked_i = 0;
  logic interrupt_active_i = 0, bias_loop_saturation_flag_i = 0, bias_overcurrent_flag_i = 0;
  logic tx_power_fault_flag_i = 0, fault_pin_i = 0, rate_select_i = 0;
  logic [1:0] bias_setpoint_sel_i = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, bias_setpoint_a_i = 0, bias_setpoint_b_i = 0, bias_setpoint_c_i = 0;
  logic [7:0] modulation_setpoint_i = 0, rx_power_input_i = 0, loss_assert_threshold_i = 8'h80;
  logic [7:0] reg_rdata_o;
  logic gp_pin_i, gp_pin_o, gp_pin_oe_n_o, table_input_select_o, internal_cal_select_o, tx_fault_o, rx_loss_o;
  logic shutdown_input_o;
  int err_count = 0;
  int n_tests = 0;
  // Config byte, fault pin, then expected select, cal, enable, pin, fault
  logic [13:0] ctab [8] = '{14'h0048, 14'h2058, 14'h0400, 14'h0604, 14'h0E02, 14'h1121, 14'h0120, 14'h1020};
  logic [8:0] ltab [4] = '{9'h170, 9'h190, 9'h0B0, 9'h090};
  ocsr_regs dut (.mclk_i, .rst_n_i, .por_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .oem_unlocked_i, .bias_setpoint_sel_i, .bias_setpoint_a_i, .bias_setpoint_b_i, .bias_setpoint_c_i,
    .modulation_setpoint_i, .interrupt_active_i, .bias_loop_saturation_flag_i, .bias_overcurrent_flag_i,
    .tx_power_fault_flag_i, .fault_pin_i, .rate_select_i, .gp_pin_i, .gp_pin_o, .gp_pin_oe_n_o, .rx_power_input_i,
    .loss_assert_threshold_i, .table_input_select_o, .internal_cal_select_o, .tx_fault_o, .shutdown_input_o,
    .rx_loss_o);
  ocsr_pin_env env (.pin_i(gp_pin_o), .oe_n_i(gp_pin_oe_n_o), .pin_lvl_o(gp_pin_i));
  initial forever #10 mclk_i = ~mclk_i;
  task check(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wr_reg(logic [7:0] a, logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge mclk_i);
    reg_wr_i = 0;
  endtask : wr_reg
  task rd_chk(logic [7:0] a, logic [7:0] e);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1;
    @(negedge mclk_i);
    reg_rd_i = 0;
    check("rdata", reg_rdata_o, e);
  endtask : rd_chk
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  initial
  begin
    #50us;
    err_count++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(negedge mclk_i);
    rst_n_i = 1;
    por_n_i = 1;
    oem_unlocked_i = 1;
    for (int i = 0; i < 6; i++)
      rd_chk(8'(8'h13 + i), i == 0 ? 8'h08 : 8'h00);
    oem_unlocked_i = 0;
    wr_reg(8'h17, 8'h5A);
    wr_reg(8'h13, 8'hFF);
    rd_chk(8'h17, 8'h00);
    oem_unlocked_i = 1;
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h13, 8'h08);
    wr_reg(8'h17, 8'hA5);
    rd_chk(8'h17, 8'hA5);
    wr_reg(8'h18, 8'hFF);
    rd_chk(8'h18, 8'h1F);
    wr_reg(8'h15, 8'hFF);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h30, 8'h00);
    {bias_setpoint_a_i, bias_setpoint_b_i, bias_setpoint_c_i, modulation_setpoint_i} = 32'h11223344;
    for (int i = 0; i < 4; i++)
    begin
      bias_setpoint_sel_i = 2'(i);
      rd_chk(8'h14, i == 0 ? 8'h11 : i == 1 ? 8'h22 : 8'h33);
    end
    rd_chk(8'h15, 8'h44);
    {interrupt_active_i, bias_loop_saturation_flag_i, bias_overcurrent_flag_i, tx_power_fault_flag_i, rate_select_i} = 5'h1B;
    repeat (4) @(negedge mclk_i);
    rd_chk(8'h16, 8'h1B);
    {interrupt_active_i, bias_loop_saturation_flag_i, bias_overcurrent_flag_i, tx_power_fault_flag_i, rate_select_i} = 5'h04;
    repeat (4) @(negedge mclk_i);
    rd_chk(8'h16, 8'h04);
    for (int i = 0; i < 8; i++)
    begin
      fault_pin_i = ctab[i][5];
      wr_reg(ctab[i][13:6] == 8'h00 ? 8'h13 : 8'h13, ctab[i][13:6]);
      repeat (4) @(negedge mclk_i);
      check("cfg", {3'h0, table_input_select_o, internal_cal_select_o, gp_pin_oe_n_o, gp_pin_o, tx_fault_o}, {3'h0, ctab[i][4:0]});
    end
    check("shutdown_input", {7'h0, shutdown_input_o}, 8'h01);
    fault_pin_i = 0;
    repeat (4) @(negedge mclk_i);
    check("shutdown_input", {7'h0, shutdown_input_o}, 8'h00);
    wr_reg(8'h18, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rx_power_input_i = ltab[i][7:0];
      repeat (3) @(negedge mclk_i);
      check("loss", {7'h0, rx_loss_o}, {7'h0, ltab[i][8]});
    end
    wr_reg(8'h18, 8'h10);
    rx_power_input_i = 8'hF0;
    repeat (3) @(negedge mclk_i);
    check("loss", {7'h0, rx_loss_o}, 8'h01);
    wr_reg(8'h13, 8'h02);
    repeat (3) @(negedge mclk_i);
    check("loss", {7'h0, rx_loss_o}, 8'h00);
    // Functional reset in mid-run must leave the retained bytes alone
    rst_n_i = 0;
    repeat (2) @(negedge mclk_i);
    check("oe_n", {7'h0, gp_pin_oe_n_o}, 8'h01);
    rst_n_i = 1;
    rd_chk(8'h13, 8'h02);
    rd_chk(8'h17, 8'hA5);
    rd_chk(8'h18, 8'h10);
    finish_test();
  end
endmodule : ocsr_regs_tb
